// ### hdl/pllsd_core.sv
// Purpose: Serial-programmed control core of an integer-N synthesizer
// Assumes: Serial clock, latch strobe, reference and prescaler ticks are
//          sampled on clk_sys; serial clock and strobe edges are found by comparing with last value
// Notes: Pump pins are an up/down/enable triple; lock pin is an out/enable pair, open-drain in analog mode
// Behaviour
// RULE1: 15-bit feedback divider from swallow and main
// RULE2: Swallow state selects prescaler modulus 33 or 32
// RULE3: Detector compares reference and feedback divider edges
// RULE4: Polarity bit sets sense of up/down commands
// RULE5: Polarity set positive, clear negative
// RULE6: Pump drives supply on up, ground down
// RULE7: Bits shift MSB first on serial rising edge
// RULE8: Last bit selects feedback or reference latch
// RULE9: Strobe rising edge loads the addressed latch
// RULE10: Reference latch field layout as documented
// RULE11: Reference divides by programmed value, two upward
// RULE12: Feedback latch field layout as documented
// RULE13: Lock rises after five small-error cycles
// RULE14: Lock falls after one large-error cycle
// RULE15: Analog lock low while pump active
// RULE16: Three-bit select picks lock pin source
// RULE17: Lock pin high in any power-down
// RULE18: Chip enable low powers down at once
// RULE19: Sleep bit stops counters, pump goes high-z
// RULE20: Control word decodes sleep, clear, async sleep
// RULE21: Clear resets dividers; restart aligned
// RULE22: Serial port works during power-down
// RULE23: High-z bit forces pump output off
`timescale 1ns/1ps
module pllsd_core #(
    parameter int REF_W = 10,
    parameter int MAIN_W = 10,
    parameter int SWAL_W = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serialClk,
    input wire logic serialData,
    input wire logic latch_strobe,
    input wire logic chipEnable,
    input wire logic refTick,
    input wire logic rfTick,
    output logic pump_outUp,
    output logic pump_outDown,
    output logic pump_outOe,
    output logic lock_pinOut,
    output logic lock_pinOe,
    output logic refDivOut,
    output logic fbDivOut
);
    typedef enum logic [1:0] {PD_IDLE, PD_UP, PD_DOWN} pllsd_pd_t;

    logic [17:0] shift_reg;
    logic [13:0] refLatch_reg;
    logic [16:0] fbLatch_reg;
    logic sclkLast_reg, strobeLast_reg, syncSleep_reg;
    logic [REF_W-1:0] refCnt_reg;
    logic [MAIN_W-1:0] mainCnt_reg;
    logic [SWAL_W-1:0] swalCnt_reg;
    logic [5:0] preCnt_reg;
    logic refPulse_reg, fbPulse_reg;
    pllsd_pd_t pd_reg, pd_next;
    logic [7:0] errCnt_reg;
    logic [2:0] goodCnt_reg;
    logic locked_reg, pumpSeen_reg;

    // Field views of the latches
    wire logic [REF_W-1:0] ref_divide_value =
        refLatch_reg[pllsd_pkg::REF_DIV_LSB-1 +: REF_W]; // [RULE10]
    wire logic pump_highz =
        refLatch_reg[pllsd_pkg::PUMP_HIGHZ_BIT-1];
    wire logic detector_polarity =
        refLatch_reg[pllsd_pkg::POLARITY_BIT-1]; // [RULE5]
    wire logic [2:0] lock_pin_select =
        refLatch_reg[pllsd_pkg::LOCK_SEL_LSB-1 +: 3]; // [RULE16]
    wire logic sleep_bit = fbLatch_reg[pllsd_pkg::SLEEP_BIT_POS-1];
    wire logic divider_clear_bit = fbLatch_reg[pllsd_pkg::CLEAR_BIT_POS-1];
    wire logic [SWAL_W-1:0] swallow_value =
        fbLatch_reg[pllsd_pkg::SWALLOW_LSB-1 +: SWAL_W]; // [RULE12]
    wire logic [MAIN_W-1:0] main_count_value =
        fbLatch_reg[pllsd_pkg::MAIN_LSB-1 +: MAIN_W];

    // Serial edge detection
    wire logic sclkRise = serialClk & ~sclkLast_reg;
    wire logic strobeRise = latch_strobe & ~strobeLast_reg;
    wire logic addrBit = shift_reg[pllsd_pkg::ADDR_BIT];

    // Power-down decode: word 11 or pin low is immediate; 01 waits
    wire logic asyncSleep = ~chipEnable |
        (sleep_bit & divider_clear_bit); // [RULE18] [RULE20]
    wire logic pumpBusy = (pd_reg != PD_IDLE);
    wire logic powerDown = asyncSleep | syncSleep_reg; // [RULE19]
    wire logic clearCounters = powerDown |
        (divider_clear_bit & ~sleep_bit); // [RULE21]

    // Shift register keeps running in power-down so it can be reloaded
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 18'h00000;
            sclkLast_reg <= 1'b0;
            strobeLast_reg <= 1'b0;
        end else begin
            sclkLast_reg <= serialClk;
            strobeLast_reg <= latch_strobe;
            if (sclkRise) begin
                shift_reg <= {shift_reg[16:0], serialData}; // [RULE7] [RULE22]
            end
        end
    end

    // Latch load on strobe rising edge, addressed by the last bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refLatch_reg <= pllsd_pkg::REF_LATCH_RST;
            fbLatch_reg <= pllsd_pkg::FB_LATCH_RST;
        end else if (strobeRise) begin
            if (addrBit == pllsd_pkg::ADDR_REFERENCE) begin // [RULE8]
                refLatch_reg <= shift_reg[14:1]; // [RULE9]
            end else begin
                fbLatch_reg <= shift_reg[17:1]; // [RULE9]
            end
        end
    end

    // Synchronous sleep waits for the pump pulse in flight to end.
    // It is kept under word 11 too, so a move to 01 never wakes the loop.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            syncSleep_reg <= 1'b0;
        end else if (!sleep_bit) begin
            syncSleep_reg <= 1'b0;
        end else if (!pumpBusy) begin
            syncSleep_reg <= 1'b1; // [RULE20]
        end
    end

    // Reference divider; values below two behave as two
    wire logic [REF_W-1:0] refTop = (ref_divide_value <
        REF_W'(pllsd_pkg::MIN_REF_DIV)) ?
        REF_W'(pllsd_pkg::MIN_REF_DIV) : ref_divide_value;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            refCnt_reg <= '0;
            refPulse_reg <= 1'b0;
        end else if (clearCounters) begin
            refCnt_reg <= '0; // [RULE19] [RULE21]
            refPulse_reg <= 1'b0;
        end else begin
            refPulse_reg <= 1'b0;
            if (refTick) begin
                // At or past the top: a smaller ratio loaded mid-count
                // must not let the counter run the long way round
                if (refCnt_reg >= refTop - REF_W'(1)) begin
                    refCnt_reg <= '0; // [RULE11]
                    refPulse_reg <= 1'b1;
                end else begin
                    refCnt_reg <= refCnt_reg + REF_W'(1);
                end
            end
        end
    end

    // Pulse swallow: modulus 33 while swallow count runs, then 32
    wire logic swallowing = (swalCnt_reg != '0);
    wire logic [5:0] preTop = swallowing ?
        6'(pllsd_pkg::PRESCALE_P) : 6'(pllsd_pkg::PRESCALE_P - 1); // [RULE2]
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_reg <= 6'h00;
            mainCnt_reg <= '0;
            swalCnt_reg <= '0;
            fbPulse_reg <= 1'b0;
        end else if (clearCounters) begin
            preCnt_reg <= 6'h00; // [RULE21]
            mainCnt_reg <= main_count_value;
            swalCnt_reg <= swallow_value;
            fbPulse_reg <= 1'b0;
        end else begin
            fbPulse_reg <= 1'b0;
            if (rfTick) begin
                if (preCnt_reg == preTop) begin
                    preCnt_reg <= 6'h00;
                    if (swallowing) begin
                        swalCnt_reg <= swalCnt_reg - SWAL_W'(1);
                    end
                    if (mainCnt_reg <= MAIN_W'(1)) begin
                        mainCnt_reg <= main_count_value; // [RULE1]
                        swalCnt_reg <= swallow_value;
                        fbPulse_reg <= 1'b1;
                    end else begin
                        mainCnt_reg <= mainCnt_reg - MAIN_W'(1);
                    end
                end else begin
                    preCnt_reg <= preCnt_reg + 6'h01;
                end
            end
        end
    end

    // Phase/frequency detector: three-state, both edges cancel
    always_comb begin
        pd_next = pd_reg;
        unique case (pd_reg)
            PD_IDLE: begin
                if (refPulse_reg & ~fbPulse_reg) begin
                    pd_next = PD_UP; // [RULE3]
                end else if (fbPulse_reg & ~refPulse_reg) begin
                    pd_next = PD_DOWN;
                end
            end
            PD_UP: begin
                if (fbPulse_reg) begin
                    pd_next = PD_IDLE;
                end
            end
            PD_DOWN: begin
                if (refPulse_reg) begin
                    pd_next = PD_IDLE;
                end
            end
            default: pd_next = PD_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pd_reg <= PD_IDLE;
        end else if (powerDown) begin
            pd_reg <= PD_IDLE; // [RULE19]
        end else begin
            pd_reg <= pd_next;
        end
    end

    // Lock filter: error width in cycles, judged when each pulse closes
    wire logic pulseEnd = pumpBusy & (pd_next == PD_IDLE);
    wire logic cycleDone = refPulse_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            errCnt_reg <= 8'h00;
            goodCnt_reg <= 3'h0;
            locked_reg <= 1'b0;
            pumpSeen_reg <= 1'b0;
        end else if (powerDown) begin
            errCnt_reg <= 8'h00;
            goodCnt_reg <= 3'h0;
            locked_reg <= 1'b0;
            pumpSeen_reg <= 1'b0;
        end else begin
            if (pumpBusy) begin
                errCnt_reg <= errCnt_reg + 8'h01;
            end
            if (pulseEnd) begin
                errCnt_reg <= 8'h00;
                if (locked_reg & (errCnt_reg + 8'h01 >
                        8'(pllsd_pkg::LOCK_EXIT_CYC))) begin
                    locked_reg <= 1'b0; // [RULE14]
                    goodCnt_reg <= 3'h0;
                end else if (!locked_reg & (errCnt_reg + 8'h01 >=
                        8'(pllsd_pkg::LOCK_ENTER_CYC))) begin
                    goodCnt_reg <= 3'h0;
                end
            end else if (cycleDone & ~pumpBusy & ~locked_reg) begin
                if (goodCnt_reg == 3'(pllsd_pkg::LOCK_COUNT - 1)) begin
                    locked_reg <= 1'b1; // [RULE13]
                end else begin
                    goodCnt_reg <= goodCnt_reg + 3'h1;
                end
            end
            pumpSeen_reg <= cycleDone ? pumpBusy : (pumpSeen_reg | pumpBusy);
        end
    end

    // Pump steering with polarity and high-z override
    wire logic upCmd = detector_polarity ? (pd_reg == PD_UP) :
        (pd_reg == PD_DOWN); // [RULE4]
    wire logic pumpOn = pumpBusy & ~pump_highz & ~powerDown; // [RULE23]
    assign pump_outOe = pumpOn; // [RULE6] [RULE18]
    assign pump_outUp = pumpOn & upCmd; // [RULE6]
    assign pump_outDown = pumpOn & ~upCmd;

    // Lock pin source mux; open-drain in analog mode
    wire logic analogMode = (lock_pin_select == pllsd_pkg::LOCK_ANALOG);
    logic lockLevel;
    always_comb begin
        lockLevel = 1'b0;
        unique case (lock_pin_select)
            pllsd_pkg::LOCK_DIGITAL: lockLevel = locked_reg;
            pllsd_pkg::LOCK_ANALOG: lockLevel = ~(pumpBusy | pumpSeen_reg);
            pllsd_pkg::LOCK_REF_OUT: lockLevel = refPulse_reg;
            pllsd_pkg::LOCK_FB_OUT: lockLevel = fbPulse_reg;
            // Factory test routes serial pins in place of the dividers
            pllsd_pkg::LOCK_TEST: lockLevel = serialClk & serialData;
            default: lockLevel = 1'b0;
        endcase
    end
    wire logic lockFinal = powerDown | lockLevel; // [RULE15] [RULE17]
    assign lock_pinOut = analogMode ? 1'b0 : lockFinal;
    assign lock_pinOe = analogMode ? ~lockFinal : 1'b1;
    assign refDivOut = refPulse_reg;
    assign fbDivOut = fbPulse_reg;
endmodule

// ### hdl/pllsd_pkg.sv
// Purpose: Shared constants for the synthesizer divider control core
// Assumes: One system clock of 50 MHz; serial and tick pins sampled on clk_sys, chipEnable also gates pump and lock outputs at once
// Notes: Field positions refer to the 18-bit serial word
package pllsd_pkg;
    localparam int SHIFT_W = 18;
    localparam int ADDR_BIT = 0;
    localparam logic ADDR_FEEDBACK = 1'b0;
    localparam logic ADDR_REFERENCE = 1'b1;
    // Reference word fields
    localparam int REF_DIV_LSB = 1;
    localparam int REF_DIV_W = 10;
    localparam int PUMP_HIGHZ_BIT = 11;
    localparam int POLARITY_BIT = 12;
    localparam int LOCK_SEL_LSB = 13;
    localparam int LOCK_SEL_W = 3;
    // Feedback word fields
    localparam int SLEEP_BIT_POS = 1;
    localparam int CLEAR_BIT_POS = 2;
    localparam int SWALLOW_LSB = 3;
    localparam int SWALLOW_W = 5;
    localparam int MAIN_LSB = 8;
    localparam int MAIN_W = 10;
    // Prescaler modulus
    localparam int PRESCALE_P = 32;
    // Lock select codes
    localparam logic [2:0] LOCK_DIGITAL = 3'h0;
    localparam logic [2:0] LOCK_ANALOG = 3'h1;
    localparam logic [2:0] LOCK_REF_OUT = 3'h2;
    localparam logic [2:0] LOCK_FB_OUT = 3'h3;
    localparam logic [2:0] LOCK_TEST = 3'h4;
    // Lock filter thresholds
    localparam int CLK_PERIOD_NS = 20;
    localparam int LOCK_ENTER_NS = 15;
    localparam int LOCK_EXIT_NS = 30;
    // Enter window is a longest time: round down, floor at one cycle
    localparam int LOCK_ENTER_CYC = (LOCK_ENTER_NS / CLK_PERIOD_NS) < 1 ?
        1 : LOCK_ENTER_NS / CLK_PERIOD_NS;
    // Exit is a least time: round up
    localparam int LOCK_EXIT_CYC =
        (LOCK_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_COUNT = 5;
    localparam int MIN_REF_DIV = 2;
    // Reset values
    localparam logic [13:0] REF_LATCH_RST = 14'h0000;
    localparam logic [16:0] FB_LATCH_RST = 17'h00000;
endpackage

// ### testbench/pllsd_core_props.sv
// Purpose: Port checks for the synthesizer control core
// Assumes: Pump outputs are combinational; divider pulses are registered
// Notes: Pulse checks hold even with ticks on every clock, as divide ratios are two or more
`timescale 1ns/1ps
module pllsd_core_props (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chipEnable,
    input wire logic pump_outUp,
    input wire logic pump_outDown,
    input wire logic pump_outOe,
    input wire logic lock_pinOut,
    input wire logic lock_pinOe,
    input wire logic refDivOut,
    input wire logic fbDivOut
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Disable pin silences the pump in the same cycle
    a_ce_pump_highz:
        assert property (!chipEnable |-> !pump_outOe)
        else $error("pump driven while disabled");
    // Pin level must read high once power-down has settled
    a_pd_lock_high:
        assert property (!chipEnable [*2] |-> (lock_pinOut || !lock_pinOe))
        else $error("lock pin low in power-down");
    a_oe_has_cmd:
        assert property (pump_outOe |-> (pump_outUp || pump_outDown))
        else $error("pump driven without a command");
    a_pump_one_dir:
        assert property (pump_outOe |-> !(pump_outUp && pump_outDown))
        else $error("pump driven both ways");
    a_ref_pulse_one:
        assert property (refDivOut |=> !refDivOut)
        else $error("reference pulse too long");
    a_fb_pulse_one:
        assert property (fbDivOut |=> !fbDivOut)
        else $error("feedback pulse too long");
    // A pulse already in flight may still land, so allow two cycles
    a_pd_ref_quiet:
        assert property (!chipEnable [*3] |-> !refDivOut)
        else $error("reference divider runs in power-down");
    a_pd_fb_quiet:
        assert property (!chipEnable [*3] |-> !fbDivOut)
        else $error("feedback divider runs in power-down");
    c_ref: cover property (refDivOut);
    c_fb: cover property (fbDivOut);
    c_pump: cover property (pump_outOe && pump_outUp);
    c_locked: cover property (chipEnable && lock_pinOe && lock_pinOut);
endmodule
bind pllsd_core pllsd_core_props u_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .chipEnable(chipEnable), .pump_outUp(pump_outUp),
    .pump_outDown(pump_outDown), .pump_outOe(pump_outOe),
    .lock_pinOut(lock_pinOut), .lock_pinOe(lock_pinOe),
    .refDivOut(refDivOut), .fbDivOut(fbDivOut));

// ### testbench/pllsd_core_tb.sv
// Purpose: Self-checking bench for the synthesizer control core
// Assumes: Reference and RF ticks pulse on every other clock
// Notes: Periods are counted in clk_sys cycles between rising edges
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
$display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module pllsd_core_tb;
    logic clk_sys = 0, rst_n = 0, chipEnable = 1, tick = 0, go = 0;
    logic [17:0] word = '0;
    logic sClk, sData, strobe, busy, up, dn, oe, lOut, lOe, rDiv, fDiv;
    logic [9:0] rv[2] = '{10'h002, 10'h3ff};
    logic [9:0] bv[2] = '{10'h003, 10'h01f};
    logic [4:0] av[2] = '{5'h01, 5'h1f};
    int n_errors = 0, tests_run = 0, p, nR, nU, nD, nO, nL, nF, nExp;
    wire lockLevel = lOe ? lOut : 1'b1; // Pulled up when released
    always #10 clk_sys = ~clk_sys;
    // One pulse train serves both tick inputs
    always @(posedge clk_sys) #1 tick = ~tick;
    pllsd_host_model u_host (.clk_sys(clk_sys), .go(go), .word(word),
        .serialClk(sClk), .serialData(sData), .latch_strobe(strobe),
        .busy(busy));
    pllsd_core DUT (.clk_sys(clk_sys), .rst_n(rst_n), .serialClk(sClk),
        .serialData(sData), .latch_strobe(strobe), .chipEnable(chipEnable),
        .refTick(tick), .rfTick(tick), .pump_outUp(up), .pump_outDown(dn),
        .pump_outOe(oe), .lock_pinOut(lOut), .lock_pinOe(lOe),
        .refDivOut(rDiv), .fbDivOut(fDiv));
    task automatic send(input logic [17:0] w);
        int t;
        t = 0;
        @(posedge clk_sys);
        #1 word = w;
        go = 1'b1;
        @(posedge clk_sys);
        #1 go = 1'b0;
        @(posedge clk_sys);
        while (busy && t < 300) begin
            @(posedge clk_sys);
            t++;
        end
        `CHK(busy, 1'b0)
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wrRef(input logic [2:0] s, input logic pol, hz,
        input logic [9:0] r);
        send({2'b00, s, pol, hz, r, 1'b1});
    endtask
    task automatic wrFb(input logic [9:0] b, input logic [4:0] a,
        input logic [1:0] c);
        send({b, a, c, 1'b0});
    endtask
    // Tally pulses, pump activity and lock pin lows over a span
    task automatic count(input int n);
        nR = 0; nU = 0; nD = 0; nO = 0; nL = 0; nF = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #2 nR += (rDiv === 1'b1);
            nO += (oe === 1'b1);
            nU += ((oe && up) === 1'b1);
            nD += ((oe && dn) === 1'b1);
            nL += (lockLevel === 1'b0);
            nF += (fDiv === 1'b1);
        end
    endtask
    task automatic period(input logic useRef);
        int t, hits;
        logic prev, cur;
        t = 0; hits = 0; p = 0; prev = 1'b1;
        while (hits < 2 && t < 5000) begin
            @(posedge clk_sys);
            #2 cur = useRef ? rDiv : lockLevel;
            if (cur === 1'b1 && prev !== 1'b1) hits++;
            if (hits == 1) p++;
            prev = cur;
            t++;
        end
    endtask
    task automatic waitLock(input logic v, input int n);
        int t;
        t = 0;
        while (lockLevel !== v && t < n) begin
            @(posedge clk_sys);
            #2 t++;
        end
        `CHK(lockLevel, v)
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Cut a hang short well past the expected run length
    initial begin
        #1500000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        wrFb(10'h003, 5'h01, 2'h0);
        wrRef(pllsd_pkg::LOCK_REF_OUT, 1'b1, 1'b0, 10'h004);
        period(1'b1); `CHK(p, 8)
        period(1'b0); `CHK(p, 8)
        foreach (rv[i]) begin
            wrRef(pllsd_pkg::LOCK_REF_OUT, 1'b1, 1'b0, rv[i]);
            period(1'b1); `CHK(p, 2 * rv[i])
        end
        wrRef(pllsd_pkg::LOCK_FB_OUT, 1'b1, 1'b0, 10'h004);
        foreach (bv[i]) begin
            wrFb(bv[i], av[i], 2'h0);
            // Feedback count is 32 per main step plus swallow
            nExp = 2 * (pllsd_pkg::PRESCALE_P * bv[i] + av[i]);
            period(1'b0);
            `CHK(p, nExp)
            // Any window one period long holds exactly one divider pulse
            count(nExp);
            `CHK(nF, 1)
        end
        // Reference runs eight times faster than feedback here
        wrFb(10'h001, 5'h00, 2'h0);
        for (int pol = 0; pol < 2; pol++) begin
            wrRef(pllsd_pkg::LOCK_ANALOG, pol[0], 1'b0, 10'h004);
            count(400);
            `CHK(nU > nD, pol[0])
            `CHK(nL > 0, 1'b1)
        end
        wrRef(pllsd_pkg::LOCK_DIGITAL, 1'b1, 1'b1, 10'h004);
        count(300); `CHK(nO, 0)
        wrFb(10'h001, 5'h00, 2'h3);
        count(200); `CHK(nR, 0)
        `CHK(nF, 0)
        `CHK(nL, 0)
        `CHK(nO, 0)
        wrRef(pllsd_pkg::LOCK_REF_OUT, 1'b1, 1'b0, 10'h002);
        wrFb(10'h001, 5'h00, 2'h1);
        count(100); `CHK(nL, 0)
        `CHK(nR, 0)
        wrFb(10'h001, 5'h00, 2'h0);
        period(1'b1); `CHK(p, 4)
        // Equal periods from an aligned restart should lock
        wrRef(pllsd_pkg::LOCK_DIGITAL, 1'b1, 1'b0, 10'h020);
        wrFb(10'h001, 5'h00, 2'h2);
        count(200); `CHK(nR, 0)
        wrFb(10'h001, 5'h00, 2'h0);
        waitLock(1'b1, 2000);
        wrRef(pllsd_pkg::LOCK_DIGITAL, 1'b1, 1'b0, 10'h01f);
        waitLock(1'b0, 1000);
        // Test routing follows the idle serial pins, which rest low
        wrRef(pllsd_pkg::LOCK_TEST, 1'b1, 1'b0, 10'h01f);
        count(20);
        `CHK(nL, 20)
        @(posedge clk_sys);
        #1 chipEnable = 1'b0;
        count(50); `CHK(nO, 0)
        `CHK(nL, 0)
        chipEnable = 1'b1;
        tally_and_finish;
    end
endmodule

// ### testbench/pllsd_host_model.sv
// Purpose: Host controller writing 18-bit words over the serial port
// Assumes: Every level holds two system clocks for the edge detector
// Notes: Serial clock idles low; data shows no stale bit when released
`timescale 1ns/1ps
module pllsd_host_model (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [17:0] word,
    output logic serialClk = 1'b0,
    output logic serialData = 1'b0,
    output logic latch_strobe = 1'b0,
    output logic busy = 1'b0
);
    // One whole word per request, then the strobe
    always begin
        @(posedge clk_sys iff go);
        #1 busy = 1'b1;
        for (int i = 17; i >= 0; i--) begin
            serialData = word[i];
            repeat (2) @(posedge clk_sys);
            #1 serialClk = 1'b1;
            repeat (2) @(posedge clk_sys);
            #1 serialClk = 1'b0;
        end
        // Released data shows the inverse of the last bit, not a stale copy
        serialData = ~word[0];
        latch_strobe = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 latch_strobe = 1'b0;
        busy = 1'b0;
    end
endmodule
